// file: scp_port.v
// serial configuration port, device side, oversampled by the system clock
// Operation
// - a frame starts on select low plus a serial clock rise, carrying a 16-bit instruction then data bytes.
// - word length 11 streams bytes until select returns high.
// - for one to three byte transfers, select high at a byte boundary stalls and the transfer resumes.
// - select high inside a byte resets the serial state and drops the partial byte.
// - select held high since reset puts the clock and data pins into their secondary function.
// - select tied low gives a two-wire mode whose framing is synchronised from reset.
// - without select activity a started stream never ends.
// - the instruction selects write or readback, and readback turns the data line around after the instruction.
// - bit order is msb first after reset and lsb first when the port configuration selects it.
// - clock and data are processed only while select is low.
// - select and clock are inputs, data is driven only during readback.
// - incoming bits are captured on serial clock rising edges.
// - writes other than port configuration and transfer go to buffered registers applied by the transfer bit.
`timescale 1ns/100ps
`include "scp_defs.vh"
module scp_port #(
  parameter ADDR_W = `SCP_ADDR_W
) (
  input wire CLOCK,
  input wire NRST,
  input wire PORT_SELECT_N,
  input wire SCLK,
  input wire SDIO_IN,
  output reg SDIO_OUT,
  output reg SDIO_OE,
  output reg [ADDR_W-1:0] REG_RADDR,
  input wire [7:0] REG_RDATA,
  output reg REG_WR,
  output reg [ADDR_W-1:0] REG_WADDR,
  output reg [7:0] REG_WDATA,
  output reg REG_XFER,
  output reg SOFT_RESET,
  output reg LSB_FIRST,
  output reg SECONDARY_MODE,
  output reg SEC_SCLK,
  output reg SEC_SDIO,
  output reg FRAME_ACTIVE
);

  localparam ST_INSTR = 1'b0;
  localparam ST_DATA = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // shift one bit into a byte in the selected order
  function [7:0] shift_in;
    input [7:0] sr;
    input d;
    input lsb;
    begin
      if (lsb)
        shift_in = {d, sr[7:1]};
      else
        shift_in = {sr[6:0], d};
    end
  endfunction

  // mirrored config byte for a given lsb-first setting
  function [7:0] cfg_value;
    input lsb;
    begin
      cfg_value = `SCP_CFG_RESET;
      cfg_value[`SCP_CFG_LSB_HI] = lsb;
      cfg_value[`SCP_CFG_LSB_LO] = lsb;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling

  wire [2:0] pins_s;
  wire sel_n_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire sdio_s = pins_s[0];
  reg sclk_prev;

  scp_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_sync (
    .CLOCK(CLOCK),
    .NRST(NRST),
    .d({PORT_SELECT_N, SCLK, SDIO_IN}),
    .q(pins_s)
  );

  wire sclk_rise = sclk_s & ~sclk_prev;
  wire sclk_fall = ~sclk_s & sclk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // frame state

  reg state;
  reg [3:0] bit_cnt;
  reg [15:0] instr_sr;
  reg [7:0] data_sr;
  reg [7:0] out_sr;
  reg rd_mode;
  reg streaming;
  reg [1:0] bytes_left;
  reg [ADDR_W-1:0] addr;

  // next values of the shifters on a rising edge
  wire [15:0] next_instr = LSB_FIRST ? {sdio_s, instr_sr[15:1]} : {instr_sr[14:0], sdio_s};
  wire [7:0] next_data = shift_in(data_sr, sdio_s, LSB_FIRST);
  wire [ADDR_W-1:0] next_addr = LSB_FIRST ? addr + {{(ADDR_W-1){1'b0}}, 1'b1} : addr - {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [7:0] rd_byte = (addr == `SCP_ADDR_PORT_CFG) ? cfg_value(LSB_FIRST) : REG_RDATA;

  // serial engine
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sclk_prev <= 1'b0;
      state <= ST_INSTR; // framing starts synchronised from reset
      bit_cnt <= 4'h0;
      instr_sr <= 16'h0000;
      data_sr <= 8'h00;
      out_sr <= 8'h00;
      rd_mode <= 1'b0;
      streaming <= 1'b0;
      bytes_left <= 2'h0;
      addr <= {ADDR_W{1'b0}};
      SDIO_OUT <= 1'b0;
      SDIO_OE <= 1'b0;
      REG_RADDR <= {ADDR_W{1'b0}};
      REG_WR <= 1'b0;
      REG_WADDR <= {ADDR_W{1'b0}};
      REG_WDATA <= 8'h00;
      REG_XFER <= 1'b0;
      SOFT_RESET <= 1'b0;
      LSB_FIRST <= 1'b0; // msb first after reset
      FRAME_ACTIVE <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      REG_WR <= 1'b0;
      REG_XFER <= 1'b0;
      SOFT_RESET <= 1'b0;
      REG_RADDR <= addr;
      if (sel_n_s) begin
        // select high gates off the serial engine
        SDIO_OE <= 1'b0; // release the line whenever deselected
        if (bit_cnt[2:0] != 3'h0 || streaming) begin
          // mid-byte abort, or end of a stream
          state <= ST_INSTR;
          bit_cnt <= 4'h0;
          streaming <= 1'b0;
          FRAME_ACTIVE <= 1'b0;
        end
        // otherwise at a byte boundary: stall, keep everything
      end else if (sclk_rise) begin
        // capture on the rising serial clock edge
        FRAME_ACTIVE <= 1'b1;
        if (state == ST_INSTR) begin
          instr_sr <= next_instr;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hf) begin
            // 16 bits in: decode rw, word length, address
            state <= ST_DATA;
            bit_cnt <= 4'h0;
            rd_mode <= next_instr[`SCP_INSTR_RW];
            bytes_left <= next_instr[`SCP_INSTR_WLEN_HI:`SCP_INSTR_WLEN_LO];
            streaming <= (next_instr[`SCP_INSTR_WLEN_HI:`SCP_INSTR_WLEN_LO] == `SCP_WLEN_STREAM);
            addr <= next_instr[ADDR_W-1:0];
          end
        end else begin
          data_sr <= next_data;
          bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
          if (bit_cnt[2:0] == 3'h7) begin
            // byte complete
            addr <= next_addr;
            if (!rd_mode) begin
              if (addr == `SCP_ADDR_PORT_CFG) begin
                // port config acts at once, either mirrored nibble counts
                SOFT_RESET <= next_data[`SCP_CFG_SRST_HI] | next_data[`SCP_CFG_SRST_LO];
                if (next_data[`SCP_CFG_SRST_HI] | next_data[`SCP_CFG_SRST_LO])
                  LSB_FIRST <= 1'b0;
                else
                  LSB_FIRST <= next_data[`SCP_CFG_LSB_HI] | next_data[`SCP_CFG_LSB_LO];
              end else begin
                // buffered registers; transfer address applies them
                REG_WR <= 1'b1;
                REG_WADDR <= addr;
                REG_WDATA <= next_data;
                REG_XFER <= (addr == `SCP_ADDR_XFER) & next_data[`SCP_XFER_BIT];
              end
            end
            if (!streaming && bytes_left == 2'h0) begin
              // last byte: release the line after the final rise
              state <= ST_INSTR;
              bit_cnt <= 4'h0;
              SDIO_OE <= 1'b0;
              FRAME_ACTIVE <= 1'b0;
            end else if (!streaming) begin
              bytes_left <= bytes_left - 2'h1;
            end
            // a stream with select tied low has no exit
          end
        end
      end else if (sclk_fall && state == ST_DATA && rd_mode) begin
        // readback: drive on the falling edge
        SDIO_OE <= 1'b1;
        if (bit_cnt[2:0] == 3'h0) begin
          SDIO_OUT <= LSB_FIRST ? rd_byte[0] : rd_byte[7];
          out_sr <= LSB_FIRST ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
        end else begin
          SDIO_OUT <= LSB_FIRST ? out_sr[0] : out_sr[7];
          out_sr <= LSB_FIRST ? {1'b0, out_sr[7:1]} : {out_sr[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary pin function

  // select held high since reset hands clock and data to secondary use
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      SECONDARY_MODE <= 1'b1;
      SEC_SCLK <= 1'b0;
      SEC_SDIO <= 1'b0;
    end else begin
      if (!sel_n_s)
        SECONDARY_MODE <= 1'b0;
      SEC_SCLK <= SECONDARY_MODE & sel_n_s & sclk_s;
      SEC_SDIO <= SECONDARY_MODE & sel_n_s & sdio_s;
    end
  end

endmodule // scp_port

// file: scp_defs.vh
// constants of the serial configuration port
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// instruction layout
`define SCP_INSTR_BITS 16
`define SCP_INSTR_RW 15
`define SCP_INSTR_WLEN_HI 14
`define SCP_INSTR_WLEN_LO 13
`define SCP_ADDR_W 13
`define SCP_WLEN_STREAM 2'h3

// special addresses
`define SCP_ADDR_PORT_CFG 13'h0000
`define SCP_ADDR_XFER 13'h00ff

// port configuration fields (nibbles mirrored)
`define SCP_CFG_LSB_HI 6
`define SCP_CFG_LSB_LO 1
`define SCP_CFG_SRST_HI 5
`define SCP_CFG_SRST_LO 2
`define SCP_CFG_RESET 8'h18
`define SCP_XFER_BIT 0

// system clock
`define SCP_CLK_PERIOD_NS 8

`endif

// file: scp_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module scp_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire CLOCK,
  input wire NRST,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // scp_sync

// file: scp_port_sva.sv
// assertions on the serial configuration port
`timescale 1ns/100ps
module scp_port_sva #(
  parameter ADDR_W = 13
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PORT_SELECT_N,
  input wire logic SCLK,
  input wire logic SDIO_OE,
  input wire logic REG_WR,
  input wire logic [ADDR_W-1:0] REG_WADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_XFER,
  input wire logic SOFT_RESET,
  input wire logic LSB_FIRST,
  input wire logic SECONDARY_MODE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // select seen high long enough to pass the synchroniser
  sequence s_idle;
    PORT_SELECT_N [*4];
  endsequence
  AST_SEL_GATE: assert property (s_idle |-> !SDIO_OE && !REG_WR)
    else $error("port active while deselected");
  AST_XFER_WR: assert property (REG_XFER |-> REG_WR && REG_WADDR == 'h0ff && REG_WDATA[0])
    else $error("transfer pulse without its write");
  AST_WR_PULSE: assert property (REG_WR |=> !REG_WR)
    else $error("write pulse too long");
  AST_CFG_LOCAL: assert property (REG_WR |-> REG_WADDR != 'h0)
    else $error("port config forwarded");
  AST_SEC_STICKY: assert property (!SECONDARY_MODE |=> !SECONDARY_MODE)
    else $error("secondary mode came back");
  AST_SEC_CLEAR: assert property ($fell(PORT_SELECT_N) |-> ##[1:5] !SECONDARY_MODE)
    else $error("secondary mode kept");
  AST_SRST_LSB: assert property (SOFT_RESET |-> ##[0:1] !LSB_FIRST)
    else $error("soft reset kept bit order");
  AST_OE_FALL: assert property ($rose(SDIO_OE) |-> !SCLK && !$past(SCLK, 2))
    else $error("drive not after clock fall");
endmodule // scp_port_sva
bind scp_port scp_port_sva #(.ADDR_W(ADDR_W)) u_sva (.CLOCK(CLOCK), .NRST(NRST), .PORT_SELECT_N(PORT_SELECT_N),
  .SCLK(SCLK), .SDIO_OE(SDIO_OE), .REG_WR(REG_WR), .REG_WADDR(REG_WADDR), .REG_WDATA(REG_WDATA),
  .REG_XFER(REG_XFER), .SOFT_RESET(SOFT_RESET), .LSB_FIRST(LSB_FIRST), .SECONDARY_MODE(SECONDARY_MODE));

// file: scp_host.sv
// host model driving the three-wire port
`timescale 1ns/100ps
module scp_host (
  input wire CLOCK,
  input wire sdi,
  output reg sel_n,
  output reg sclk,
  output reg sdo
);
  reg [23:0] rd = 24'h0;
  initial sel_n = 1'b1;
  initial sclk = 1'b0;
  initial sdo = 1'b0;
  //////////////////////
  // wait whole clock cycles
  task automatic rep(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // move select and let it settle
  task automatic sel(input logic v);
    sel_n <= v;
    rep(4);
  endtask
  // move clock and data pins while deselected
  task automatic pins(input logic c, input logic v);
    sclk <= c;
    sdo <= v;
    rep(4);
  endtask
  // shift bits msb first, 160 ns clock, sample line on each rise
  task automatic sh(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdo <= v[i];
      rep(10);
      sclk <= 1'b1;
      rep(1);
      rd <= {rd[22:0], sdi};
      rep(9);
      sclk <= 1'b0;
    end
  endtask
  // whole frame, optional stall after the instruction
  task automatic frame(input logic [15:0] ins, input logic [23:0] v, input int n, input bit stall);
    sel(1'b0);
    sh({8'h0, ins}, 16);
    if (stall) begin
      sel(1'b1);
      sel(1'b0);
    end
    sh(v, 8 * n);
    sel(1'b1);
  endtask
endmodule // scp_host

// file: serial_config_port_tb.sv
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
module serial_config_port_tb;
  reg CLOCK = 1'b0;
  reg NRST = 1'b0;
  reg [7:0] rdata = 8'h0;
  wire sel_n, sclk, sdo, s_out, s_oe, wr, xfer, srst, lsb, sec, sec_sclk, sec_sdio, fa;
  wire [12:0] raddr, waddr;
  wire [7:0] wdata;
  wire line = s_oe ? s_out : sdo;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int xcnt = 0;
  int scnt = 0;
  logic [20:0] wq[$];
  logic [12:0] a;
  logic [23:0] d;
  always #4 CLOCK = ~CLOCK;
  scp_host u_host (.CLOCK(CLOCK), .sdi(line), .sel_n(sel_n), .sclk(sclk), .sdo(sdo));
  scp_port u_dut (.CLOCK(CLOCK), .NRST(NRST), .PORT_SELECT_N(sel_n), .SCLK(sclk), .SDIO_IN(line), .SDIO_OUT(s_out),
    .SDIO_OE(s_oe), .REG_RADDR(raddr), .REG_RDATA(rdata), .REG_WR(wr), .REG_WADDR(waddr), .REG_WDATA(wdata),
    .REG_XFER(xfer), .SOFT_RESET(srst), .LSB_FIRST(lsb), .SECONDARY_MODE(sec), .SEC_SCLK(sec_sclk),
    .SEC_SDIO(sec_sdio), .FRAME_ACTIVE(fa));
  //////////////////////
  // register file contents, write log and hang limit
  always @(posedge CLOCK) begin
    rdata <= raddr[7:0] ^ 8'h5a;
    cyc <= cyc + 1;
    if (wr === 1'b1) wq.push_back({waddr, wdata});
    if (xfer === 1'b1) xcnt <= xcnt + 1;
    if (srst === 1'b1) scnt <= scnt + 1;
    if (cyc == 30000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [7:0] rexp(input logic [12:0] ra);
    return ra[7:0] ^ 8'h5a;
  endfunction
  // bit order helpers for lsb-first frames sent by the msb-first host
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rev16[15 - i] = v[i];
  endfunction
  function automatic logic [23:0] rev_bytes(input logic [23:0] v);
    for (int i = 0; i < 24; i++)
      rev_bytes[(i / 8) * 8 + 7 - i % 8] = v[i];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic expw(input logic [12:0] ea, input logic [7:0] ed);
    chk(wq.size() ? wq.pop_front() : 21'h1fffff, {ea, ed});
  endtask
  task automatic test_done();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////
  // main sequence
  initial begin
    d = $urandom(32'h464549ea);
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    u_host.rep(8);
    chk(sec, 1);
    u_host.pins(1'b1, 1'b1);
    chk(sec_sclk, 1);
    chk(sec_sdio, 1);
    u_host.pins(1'b0, 1'b0);
    chk(sec_sclk, 0);
    for (int k = 0; k < 4; k++) begin
      a = 13'h200 | 13'($urandom % 256);
      d = $urandom;
      u_host.frame({3'b001, a}, d, 2, k[0]);
      expw(a, d[15:8]);
      expw(a - 1, d[7:0]);
    end
    u_host.frame({3'b100, a}, 24'haaaaaa, 1, 0);
    chk(u_host.rd[7:0], rexp(a));
    u_host.frame({3'b111, a}, 24'h0, 2, 0);
    chk(u_host.rd[15:0], {rexp(a), rexp(a - 1)});
    // abort inside a data byte: partial byte must not be written
    u_host.sel(1'b0);
    u_host.sh({8'h0, 3'b000, a}, 16);
    u_host.sh(24'h3, 4);
    chk(fa, 1);
    u_host.sel(1'b1);
    chk(fa, 0);
    chk(wq.size(), 0);
    u_host.sel(1'b0);
    u_host.sh(24'h5, 5);
    u_host.sel(1'b1);
    u_host.frame({3'b011, a}, d, 3, 0);
    expw(a, d[23:16]);
    expw(a - 1, d[15:8]);
    expw(a - 2, d[7:0]);
    u_host.frame({3'b000, 13'h0ff}, 24'h1, 1, 0);
    chk(xcnt, 1);
    expw(13'h0ff, 8'h01);
    u_host.frame(16'h0, 24'h42, 1, 0);
    chk(lsb, 1);
    chk(wq.size(), 0);
    u_host.frame(rev16({3'b001, a}), rev_bytes(d), 2, 0);
    expw(a, d[15:8]);
    expw(a + 1, d[7:0]);
    // port config read back lsb first: 0x18 with both lsb-first bits set
    u_host.frame(rev16(16'h8000), 24'h0, 1, 0);
    chk(u_host.rd[7:0], 8'h5a);
    u_host.frame(16'h0, 24'h24, 1, 0);
    chk(lsb, 0);
    chk(scnt, 1);
    u_host.frame({3'b100, 13'h0}, 24'h0, 1, 0);
    chk(u_host.rd[7:0], 8'h18);
    // two-wire: select stays low over two back-to-back frames
    u_host.sel(1'b0);
    u_host.sh({8'h0, 3'b000, a}, 16);
    u_host.sh(d, 8);
    u_host.sh({8'h0, 3'b000, a}, 16);
    u_host.sh(d >> 8, 8);
    u_host.sel(1'b1);
    expw(a, d[7:0]);
    expw(a, d[15:8]);
    chk(sec, 0);
    u_host.pins(1'b1, 1'b1);
    chk(sec_sclk, 0);
    chk(sec_sdio, 0);
    u_host.pins(1'b0, 1'b0);
    test_done();
  end
endmodule // serial_config_port_tb
